// ### hw/ugie_regs.vh
// Register map, field positions and reset values of the general event block.
// Included by the design files; definitions only.
`ifndef UGIE_REGS_VH
`define UGIE_REGS_VH

// Printed offsets are indices; byte address is four times the index
`define UGIE_IDX_STATUS     8'h0A
`define UGIE_IDX_ENABLE     8'h0B
`define UGIE_IDX_CONFIG     8'h0D
`define UGIE_ADDR_STATUS    10'h028
`define UGIE_ADDR_ENABLE    10'h02C
`define UGIE_ADDR_CONFIG    10'h034

`define UGIE_STATUS_RST     8'h00
`define UGIE_ENABLE_RST     8'h06

// Host layout
`define UGIE_H_DETACH       5
`define UGIE_H_ATTACH       4
`define UGIE_H_SOF          3
`define UGIE_H_BABBLE       2
`define UGIE_H_RESUME       1
`define UGIE_H_MASK         8'h3E

// Device layout
`define UGIE_D_SOF          3
`define UGIE_D_BUSRST       2
`define UGIE_D_RESUME       1
`define UGIE_D_SUSPEND      0
`define UGIE_D_MASK         8'h0F

// Config register: bit 0 reads the synchronised host role level; writes have no effect
`define UGIE_CFG_HOST       0

// Byte lane that carries every register
`define UGIE_LANE_CTRL      0

// Synchronised levels start in device role, not suspended
`define UGIE_LEVEL_RST      1'b0
`define UGIE_RDATA_RST      32'h0000_0000

`endif

// ### hw/ugie_sync.v
// Three-stage input synchroniser with agreement on stages two and three.
// Assumes the input is asynchronous to clk_i; one instance per pin.
`timescale 1ns/1ps
module ugie_sync
#(
  parameter RESET_VAL = 1'b0
)
(
  // Clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // Async input and filtered level
  input  wire d_i,
  output wire q_o
);

  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  reg q_ff;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_ff <= RESET_VAL;
      s2_ff <= RESET_VAL;
      s3_ff <= RESET_VAL;
      q_ff  <= RESET_VAL;
    end
    else
    begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // Change counts only once stages two and three agree
      if (s2_ff == s3_ff)
        q_ff <= s3_ff;
    end
  end

  assign q_o = q_ff;

endmodule // ugie_sync

// ### hw/ugie_top.v
// General event status and enable logic of a USB controller, Wishbone slave.
// Assumes event strobes come as one-cycle pulses from the controller core on
// clk_i, and that the role and suspend levels come from pins (synchronised).
//
// Overview of operation
// - Host role: status bit 1 set on resume seen while suspended.
// - Device role: status bit 3 set per new frame; bits 7:4 read zero.
// - Device role: status bit 2 set on bus reset signalling.
// - Device role: status bit 1 set on resume seen while suspended.
// - Device role: status bit 0 set on suspend signalling.
// - Status is 8 bits, resets to zero; enable bit gates same position.
// - Interrupt high while any status bit and its enable are both set.
// - Enable register resets to 0x06.
// - Host: enable 5 detach, 4 attach, reset 0; bits 7:6 read zero.
// - Host: enable 3 gates frame start, reset 0; bit 0 reads zero.
// - Host: enable 2 babble, enable 1 resume, both reset 1.
// - Device: enable 1 gates resume like the host layout.
// - Reading status returns every set flag, enabled or not, and clears them in that access.
// - Host: status 5 detach, 4 attach, 3 frame start.
// - Host: babble flag only after first frame start has been sent.
// - Device: enable 2 bus reset reset 1, enable 0 suspend reset 0.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`include "ugie_regs.vh"
module ugie_top
(
  // System
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [9:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  output wire        wb_err_o,
  // Controller core events, one-cycle pulses on clk_i
  input  wire        ev_attach_i,
  input  wire        ev_detach_i,
  input  wire        ev_sof_i,
  input  wire        ev_babble_i,
  input  wire        ev_resume_i,
  input  wire        ev_busrst_i,
  input  wire        ev_suspend_i,
  // Asynchronous levels
  input  wire        host_role_i,
  input  wire        suspended_i,
  // Interrupt
  output wire        irq_o
);

  // Registers
  reg  [7:0]  status_ff;
  reg  [7:0]  nxt_status;
  reg  [7:0]  enable_ff;
  reg  [7:0]  nxt_enable;
  reg         sof_seen_ff;
  reg         nxt_sof_seen;
  reg         ack_ff;
  reg         nxt_ack;
  reg         err_ff;
  reg         nxt_err;
  reg  [31:0] rdata_ff;
  reg  [31:0] nxt_rdata;
  // Combinational helpers
  reg  [7:0]  set_vec;
  reg  [7:0]  host_set;
  reg  [7:0]  dev_set;
  reg  [7:0]  clr_vec;
  reg         map_hit;
  reg  [7:0]  rd_byte;
  // Synchronised levels
  wire        host_role;
  wire        suspended;
  // Qualified event strobes
  wire        q_detach;
  wire        q_attach;
  wire        q_sof;
  wire        q_babble;
  wire        q_resume;
  wire        q_busrst;
  wire        q_suspend;
  // Bus decode
  wire        req;
  wire        lane0;
  wire        hit_status;
  wire        hit_enable;
  wire        hit_config;
  wire        rd_req;
  wire        wr_req;
  wire        rd_status;
  wire        wr_enable;
  // Layout view
  wire [7:0]  lay_mask;
  wire [7:0]  status_view;
  wire [7:0]  enable_view;
  wire [7:0]  pending;

  ugie_sync
  #(
    .RESET_VAL (`UGIE_LEVEL_RST)
  )
  u_sync_role
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (host_role_i),
    .q_o   (host_role)
  );

  ugie_sync
  #(
    .RESET_VAL (`UGIE_LEVEL_RST)
  )
  u_sync_susp
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (suspended_i),
    .q_o   (suspended)
  );

  // One access per request; a high ack or err blocks a second take
  assign req        = wb_cyc_i & wb_stb_i & ~ack_ff & ~err_ff;
  assign lane0      = wb_sel_i[`UGIE_LANE_CTRL];
  assign hit_status = (wb_adr_i == `UGIE_ADDR_STATUS);
  assign hit_enable = (wb_adr_i == `UGIE_ADDR_ENABLE);
  assign hit_config = (wb_adr_i == `UGIE_ADDR_CONFIG);
  assign rd_req     = req & ~wb_we_i;
  assign wr_req     = req & wb_we_i;
  // Read-clear needs lane 0, so a read of upper bytes alone loses nothing
  assign rd_status  = rd_req & hit_status & lane0;
  assign wr_enable  = wr_req & hit_enable & lane0;

  // Reserved positions per role read as zero
  assign lay_mask    = host_role ? `UGIE_H_MASK : `UGIE_D_MASK;
  assign status_view = status_ff & lay_mask;
  assign enable_view = enable_ff & lay_mask;
  assign pending     = status_view & enable_view;

  // Events qualified by role; resume only counts while suspended
  assign q_detach  = host_role & ev_detach_i;
  assign q_attach  = host_role & ev_attach_i;
  assign q_sof     = ev_sof_i;
  assign q_babble  = host_role & ev_babble_i & sof_seen_ff;
  assign q_resume  = ev_resume_i & suspended;
  assign q_busrst  = ~host_role & ev_busrst_i;
  assign q_suspend = ~host_role & ev_suspend_i;

  always @*
  begin
    host_set                 = 8'h00;
    host_set[`UGIE_H_DETACH] = q_detach;
    host_set[`UGIE_H_ATTACH] = q_attach;
    host_set[`UGIE_H_SOF]    = q_sof;
    host_set[`UGIE_H_BABBLE] = q_babble;
    host_set[`UGIE_H_RESUME] = q_resume;
  end

  always @*
  begin
    dev_set                  = 8'h00;
    dev_set[`UGIE_D_SOF]     = q_sof;
    dev_set[`UGIE_D_BUSRST]  = q_busrst;
    dev_set[`UGIE_D_RESUME]  = q_resume;
    dev_set[`UGIE_D_SUSPEND] = q_suspend;
  end

  always @*
  begin
    if (host_role)
    begin
      set_vec = host_set;
    end
    else
    begin
      set_vec = dev_set;
    end
  end

  // Read-clear drops every flag that the read returned
  always @*
  begin
    clr_vec = 8'h00;
    if (rd_status)
    begin
      clr_vec = 8'hFF;
    end
  end

  // Set wins over the read-clear so a same-cycle event is not lost
  always @*
  begin
    nxt_status = status_ff & ~clr_vec;
    nxt_status = nxt_status | set_vec;
    nxt_status = nxt_status & lay_mask;
  end

  // All eight bits stored; the layout mask decides what reads and gates
  always @*
  begin
    nxt_enable = enable_ff;
    if (wr_enable)
    begin
      nxt_enable = wb_dat_i[7:0];
    end
  end

  // Babble arms after the first frame start sent as host; device role disarms it
  always @*
  begin
    nxt_sof_seen = sof_seen_ff;
    if (!host_role)
    begin
      nxt_sof_seen = 1'b0;
    end
    else if (ev_sof_i)
    begin
      nxt_sof_seen = 1'b1;
    end
  end

  always @*
  begin
    map_hit = 1'b1;
    rd_byte = 8'h00;
    case (wb_adr_i)
      `UGIE_ADDR_STATUS:
      begin
        rd_byte = status_view;
      end
      `UGIE_ADDR_ENABLE:
      begin
        rd_byte = enable_view;
      end
      `UGIE_ADDR_CONFIG:
      begin
        rd_byte = {7'h00, host_role};
      end
      default:
      begin
        map_hit = 1'b0;
      end
    endcase
  end

  // Upper bytes always zero; data holds until the next taken request
  always @*
  begin
    nxt_rdata = rdata_ff;
    if (req)
    begin
      nxt_rdata = {24'h00_0000, rd_byte};
    end
  end

  // Answer one cycle after the take; unmapped addresses get err and no effect
  always @*
  begin
    nxt_ack = 1'b0;
    nxt_err = 1'b0;
    if (req)
    begin
      nxt_ack = map_hit;
      nxt_err = ~map_hit;
    end
  end

  // Event flags and enables
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status_ff   <= `UGIE_STATUS_RST;
      enable_ff   <= `UGIE_ENABLE_RST;
      sof_seen_ff <= 1'b0;
    end
    else
    begin
      status_ff   <= nxt_status;
      enable_ff   <= nxt_enable;
      sof_seen_ff <= nxt_sof_seen;
    end
  end

  // Bus answer
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff   <= 1'b0;
      err_ff   <= 1'b0;
      rdata_ff <= `UGIE_RDATA_RST;
    end
    else
    begin
      ack_ff   <= nxt_ack;
      err_ff   <= nxt_err;
      rdata_ff <= nxt_rdata;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_err_o = err_ff;
  assign wb_dat_o = rdata_ff;

  // Same gating for both layouts, only the positions differ
  assign irq_o = |pending;

endmodule // ugie_top

// ### verification/ugie_chk.sv
// Port-level checker of the general event block.
// Assumes only the top module's ports; attached by bind.
`timescale 1ns/1ps
module ugie_chk
(
  // System
  input wire        clk_i,
  input wire        rst_i,
  // Bus
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [9:0]  wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        wb_err_o,
  // Events and interrupt
  input wire        ev_attach_i,
  input wire        ev_detach_i,
  input wire        ev_sof_i,
  input wire        ev_babble_i,
  input wire        ev_resume_i,
  input wire        ev_busrst_i,
  input wire        ev_suspend_i,
  input wire        irq_o
);
  wire any_ev = ev_attach_i | ev_detach_i | ev_sof_i | ev_babble_i |
                ev_resume_i | ev_busrst_i | ev_suspend_i;
  wire req    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire rd_st  = wb_ack_o & ~wb_we_i & (wb_adr_i == 10'h028);
  wire mapped = wb_adr_i == 10'h028 || wb_adr_i == 10'h02C || wb_adr_i == 10'h034;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  rst_irq_a: assert property ($fell(rst_i) |-> !irq_o)
    else $error("irq high after reset");
  ans_lat_a: assert property (req |=> wb_ack_o || wb_err_o)
    else $error("no answer one cycle after request");
  unmap_err_a: assert property (req && !mapped |=> wb_err_o && !wb_ack_o)
    else $error("unmapped address not refused");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  stat_high_a: assert property (rd_st |-> wb_dat_o[31:6] == 26'h0)
    else $error("status reserved bits set");
  en_high_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 10'h02C |->
    wb_dat_o[31:6] == 26'h0) else $error("enable reserved bits set");
  rc_irq_a: assert property (rd_st && !$past(any_ev) |-> !irq_o)
    else $error("irq left after status read");
  irq_src_a: assert property ($rose(irq_o) |-> $past(any_ev) || wb_ack_o && wb_we_i)
    else $error("irq rose without cause");
endmodule // ugie_chk
bind ugie_top ugie_chk ugie_chk_i (.*);

// ### verification/ugie_usb.sv
// Stand-in for the controller core: event pulses, role and suspend levels.
// Assumes the bench calls pulse between bus accesses.
`timescale 1ns/1ps
module ugie_usb
(
  // Clock
  input  wire       clk_i,
  // Events: attach, detach, sof, babble, resume, busrst, suspend
  output reg  [6:0] ev_o,
  output reg        role_o,
  output reg        susp_o
);
  // Clock never gated here, so the resume flag is usable
  initial
  begin
    ev_o = 7'h00;
    role_o = 1'b0;
    susp_o = 1'b1;
  end
  task pulse(input [6:0] m);
    begin
      @(posedge clk_i);
      ev_o <= m;
      @(posedge clk_i);
      ev_o <= 7'h00;
    end
  endtask
endmodule // ugie_usb

// ### verification/ugie_top_tb_top.sv
// Bench of the general event block: registers, event flags, interrupt.
// Assumes the header directory is on the include path.
`timescale 1ns/1ps
`include "ugie_regs.vh"
module ugie_top_tb_top;
  localparam [9:0] ST = `UGIE_ADDR_STATUS;
  localparam [9:0] EN = `UGIE_ADDR_ENABLE;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         cyc = 1'b0;
  reg         we = 1'b0;
  reg  [9:0]  adr = 10'h000;
  reg  [31:0] wd = 32'h0;
  reg  [31:0] rd;
  reg         ge;
  wire [31:0] dat;
  wire        ack, err, irq;
  wire [6:0]  ev;
  wire        role, susp;
  integer     n_errors = 0;
  integer     n_checks = 0;
  integer     k;
  always #10 clk_i = ~clk_i;
  ugie_top ugie_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(dat),
    .wb_ack_o(ack), .wb_err_o(err), .ev_attach_i(ev[0]), .ev_detach_i(ev[1]),
    .ev_sof_i(ev[2]), .ev_babble_i(ev[3]), .ev_resume_i(ev[4]), .ev_busrst_i(ev[5]),
    .ev_suspend_i(ev[6]), .host_role_i(role), .suspended_i(susp), .irq_o(irq));
  ugie_usb ugie_usb_i (.clk_i(clk_i), .ev_o(ev), .role_o(role), .susp_o(susp));
  task results;
    begin
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e)
      begin
        n_errors = n_errors + 1;
        $display("ERROR %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Waits for ack or err; bounded so a dead slave ends the run
  task wb(input [9:0] a, input w, input [7:0] d);
    begin
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wd <= {24'h0, d};
      k = 0;
      @(posedge clk_i);
      while (ack !== 1'b1 && err !== 1'b1 && k < 20)
      begin
        k = k + 1;
        @(posedge clk_i);
      end
      if (k == 20)
      begin
        n_errors = n_errors + 1;
        results;
      end
      rd = dat;
      ge = err;
      cyc <= 1'b0;
    end
  endtask
  task chk_irq(input e);
    begin
      @(negedge clk_i);
      chk("irq", {31'h0, e}, {31'h0, irq});
    end
  endtask
  task t_reset;
    begin
      wb(EN, 0, 0);
      chk("enable", 32'h06, rd);
      wb(ST, 0, 0);
      chk("status", 32'h00, rd);
      wb(10'h3FC, 0, 0);
      chk("unmapped err", 32'h1, {31'h0, ge});
    end
  endtask
  task t_dev;
    begin
      wb(EN, 1, 8'h00);
      ugie_usb_i.pulse(7'h74);
      chk_irq(0);
      wb(EN, 1, 8'h0F);
      chk_irq(1);
      wb(ST, 0, 0);
      chk("status", 32'h0F, rd);
      chk_irq(0);
      wb(ST, 0, 0);
      chk("status", 32'h00, rd);
      ugie_usb_i.susp_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      ugie_usb_i.pulse(7'h10);
      wb(ST, 0, 0);
      chk("status", 32'h00, rd);
    end
  endtask
  task t_rerst;
    begin
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      wb(EN, 0, 0);
      chk("enable", 32'h06, rd);
      chk_irq(0);
      wb(ST, 0, 0);
      chk("status", 32'h00, rd);
    end
  endtask
  task t_host;
    begin
      ugie_usb_i.role_o <= 1'b1;
      ugie_usb_i.susp_o <= 1'b1;
      repeat (8) @(posedge clk_i);
      wb(`UGIE_ADDR_CONFIG, 0, 0);
      chk("config", 32'h01, rd);
      wb(EN, 0, 0);
      chk("enable", 32'h0E, rd);
      ugie_usb_i.pulse(7'h08);
      wb(ST, 0, 0);
      chk("status", 32'h00, rd);
      ugie_usb_i.pulse(7'h04);
      ugie_usb_i.pulse(7'h1B);
      chk_irq(1);
      wb(ST, 0, 0);
      chk("status", 32'h3E, rd);
      wb(EN, 1, 8'hFF);
      wb(EN, 0, 0);
      chk("enable", 32'h3E, rd);
    end
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    t_reset;
    t_dev;
    t_host;
    t_rerst;
    results;
  end
endmodule // ugie_top_tb_top
